// [core/banked_register_file_stack.sv]
// Purpose: banked general registers, pointer extensions, status word
//          bank and remap bits, system and user stack pointers
// Assumes: one operation per cycle from the execution unit
// Notes:   every operation except OP_NOP is answered by done_q one edge later
// How it works
// [RULE1] a 24-bit stack pointer addresses a stack anywhere in 1 Mbyte
// [RULE2] software loads the pointer with its upper four bits zero
// [RULE3] pointer drops before each push, rises after each pop
// [RULE4] software loads the pointer right after reset, before any call
// [RULE5] non-maskable requests are taken even before the pointer is loaded
// [RULE6] software keeps the stack out of peripheral and ROM regions
// [RULE7] sixteen byte registers per bank, adjacent pairs form words
// [RULE8] four pairs plus an extension byte form 24-bit pointers
// [RULE9] only the four extension bytes are flops, the rest is RAM
// [RULE10] eight banks, switched by select or by context switch
// [RULE11] reset selects bank zero, readable in the status word
// [RULE12] bank RAM is also data memory in a 128-byte window
// [RULE13] high placement adds 0F0000H to every register address
// [RULE14] remap moves implicit bytes to 4..7 and words to pairs 2, 3
// [RULE15] absolute register numbers ignore the remap bit
// [RULE16] context switch saves low 16 program counter bits in pair 2
// [RULE17] context switch saves high counter bits and status in pair 3
// [RULE18] vector acknowledge pushes status, return restores it
// [RULE19] accumulator pair and pair 6 form one 32-bit operand
// [RULE20] byte registers 2 and 3 serve as loop counters
// [RULE21] byte register 2 counts string and compare iterations
// [RULE22] second pointer register serves as the user stack pointer
// [RULE23] bank field is three bits, value selects the bank directly
// [RULE24] remap is bit 5 of the low status byte, zero is normal
// [RULE25] RAM index comes from bank, remap and number in one step
`default_nettype none

module banked_register_file_stack #(
    parameter int BANKS = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire regfile_pkg::op_t op,
    input wire logic [3:0] sel,
    input wire logic implicit,
    input wire logic [31:0] wdata,
    input wire logic location_high,
    input wire logic nmi_req,
    output logic done_q,
    output logic [31:0] rdata_q,
    output logic zero_q,
    output logic [15:0] psw_q,
    output logic [23:0] sp_q,
    output logic sp_valid_q,
    output logic [19:0] stk_addr_q,
    output logic [15:0] stk_wdata_q,
    output logic stk_we_q,
    output logic mem_hit_q,
    output logic nmi_accept_q
);

    typedef struct packed {
        logic [15:0] processor_status_word;
        logic [23:0] sp;
        logic sp_valid;
        logic [3:0][7:0] ext;
        logic done;
        logic [31:0] rdata;
        logic zero;
        logic [19:0] stk_addr;
        logic [15:0] stk_wdata;
        logic stk_we;
        logic mem_hit;
        logic nmi_accept;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [2:0] bank;
    logic remap;
    logic map_wide;
    logic map_implicit;
    logic [3:0] map_num;
    logic [5:0] map_widx;
    logic map_hi;
    logic [5:0] rd0_idx;
    logic [5:0] rd1_idx;
    logic [15:0] rd0_data;
    logic [15:0] rd1_data;
    logic [1:0] wr_en;
    logic [1:0][5:0] wr_idx;
    logic [1:0][1:0] wr_be;
    logic [1:0][15:0] wr_data;
    logic [7:0] byte_val;
    logic [7:0] loop_next;
    logic [23:0] step;
    logic [23:0] uptr;
    logic [23:0] uptr_next;
    logic [19:0] win_base;
    logic [19:0] win_off;
    logic win_hit;
    logic [2:0] ctx_bank;
    logic [19:0] ctx_pc;
    logic [19:0] sp_addr;

    // [RULE23] three-bit bank field
    assign bank = s_q.processor_status_word[regfile_pkg::PSW_BANK_LSB +: regfile_pkg::BANK_W];
    // [RULE24] remap bit in low status byte
    assign remap = s_q.processor_status_word[regfile_pkg::PSW_REMAP_BIT];
    assign step = {22'h0, sel[1:0]};
    assign ctx_bank = wdata[22:20];
    assign ctx_pc = wdata[19:0];
    assign sp_addr = s_q.sp[19:0];

    // ========================================================
    // name decode and bank storage
    // ========================================================
    // [RULE25] single-step index decode
    reg_name_map u_map (
        .bank(bank),
        .remap(remap),
        .implicit(map_implicit),
        .wide(map_wide),
        .num(map_num),
        .widx(map_widx),
        .hi(map_hi)
    );

    // [RULE9] general registers held in RAM
    regbank_ram #(
        .WORDS(BANKS * 8)
    ) u_ram (
        .mclk(mclk),
        .rd0_idx(rd0_idx),
        .rd0_data(rd0_data),
        .rd1_idx(rd1_idx),
        .rd1_data(rd1_data),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_be(wr_be),
        .wr_data(wr_data)
    );

    // ========================================================
    // data memory window
    // ========================================================
    always_comb
    begin
        // [RULE13] relocation of the window
        win_base = location_high
            ? regfile_pkg::RF_BASE_LOW + regfile_pkg::RELOC_OFFSET
            : regfile_pkg::RF_BASE_LOW;
        win_off = wdata[19:0] - win_base;
        // [RULE12] window hit check
        win_hit = (wdata[19:0] >= win_base) &&
                  (win_off < regfile_pkg::RF_WIN_SIZE);
    end

    // ========================================================
    // operation decode
    // ========================================================
    always_comb
    begin
        s_d = s_q;
        s_d.done = op != regfile_pkg::OP_NOP;
        s_d.stk_we = 1'b0;
        s_d.mem_hit = 1'b0;
        // [RULE5] acceptance never looks at sp_valid
        s_d.nmi_accept = nmi_req;
        // [RULE19] quad and loop ops use implicit names
        map_wide = op inside {regfile_pkg::OP_RD16, regfile_pkg::OP_WR16,
                              regfile_pkg::OP_RD32, regfile_pkg::OP_WR32};
        map_implicit = implicit || op inside {regfile_pkg::OP_LOOP_DEC,
            regfile_pkg::OP_RD32, regfile_pkg::OP_WR32};
        map_num = sel;
        if (op inside {regfile_pkg::OP_RD32, regfile_pkg::OP_WR32})
        begin
            map_num = 4'h0;
        end
        // [RULE20] C or B as loop counter
        if (op == regfile_pkg::OP_LOOP_DEC)
        begin
            map_num = {regfile_pkg::LOOP_C_CODE[3:1], sel[0]};
        end
        rd0_idx = map_widx;
        rd1_idx = regfile_pkg::pair_index(bank, regfile_pkg::QUAD_LOW_PAIR);
        wr_en = 2'b00;
        wr_idx[0] = map_widx;
        wr_idx[1] = rd1_idx;
        wr_be[0] = map_hi ? 2'b10 : 2'b01;
        wr_be[1] = 2'b11;
        wr_data[0] = {wdata[7:0], wdata[7:0]};
        wr_data[1] = wdata[15:0];
        byte_val = map_hi ? rd0_data[15:8] : rd0_data[7:0];
        loop_next = byte_val - 8'h01;
        uptr = 24'h000000;
        uptr_next = 24'h000000;
        unique case (op)
            regfile_pkg::OP_NOP:
            begin
            end
            // [RULE7] byte access
            regfile_pkg::OP_RD8:
            begin
                s_d.rdata = {24'h000000, byte_val};
            end
            regfile_pkg::OP_WR8:
            begin
                wr_en[0] = 1'b1;
            end
            // [RULE7] word access to a pair
            regfile_pkg::OP_RD16:
            begin
                s_d.rdata = {16'h0000, rd0_data};
            end
            regfile_pkg::OP_WR16:
            begin
                wr_en[0] = 1'b1;
                wr_be[0] = 2'b11;
                wr_data[0] = wdata[15:0];
            end
            // [RULE8] 24-bit pointer as one unit
            regfile_pkg::OP_RD24:
            begin
                rd1_idx = regfile_pkg::pair_index(bank, {1'b1, sel[1:0]});
                s_d.rdata = {8'h00, s_q.ext[sel[1:0]], rd1_data};
            end
            regfile_pkg::OP_WR24:
            begin
                rd1_idx = regfile_pkg::pair_index(bank, {1'b1, sel[1:0]});
                wr_idx[1] = rd1_idx;
                wr_en[1] = 1'b1;
                s_d.ext[sel[1:0]] = wdata[23:16];
            end
            // [RULE19] 32-bit operand, accumulator pair high
            regfile_pkg::OP_RD32:
            begin
                s_d.rdata = {rd0_data, rd1_data};
            end
            regfile_pkg::OP_WR32:
            begin
                wr_en = 2'b11;
                wr_be[0] = 2'b11;
                wr_data[0] = wdata[31:16];
            end
            // [RULE21] counter decrement and zero flag
            regfile_pkg::OP_LOOP_DEC:
            begin
                wr_en[0] = 1'b1;
                wr_data[0] = {loop_next, loop_next};
                s_d.rdata = {24'h000000, loop_next};
                s_d.zero = loop_next == 8'h00;
            end
            // [RULE1] full 24-bit load
            regfile_pkg::OP_SP_LOAD:
            begin
                s_d.sp = wdata[23:0];
                s_d.sp_valid = 1'b1;
            end
            // [RULE3] decrement before the write
            regfile_pkg::OP_SP_PUSH:
            begin
                s_d.sp = s_q.sp - step;
                s_d.stk_addr = s_d.sp[19:0];
                s_d.stk_we = 1'b1;
            end
            // [RULE3] increment after the read
            regfile_pkg::OP_SP_POP:
            begin
                s_d.stk_addr = sp_addr;
                s_d.sp = s_q.sp + step;
            end
            // [RULE22] user stack on the second pointer
            regfile_pkg::OP_USP_PUSH, regfile_pkg::OP_USP_POP:
            begin
                rd1_idx = regfile_pkg::pair_index(bank, regfile_pkg::USP_PAIR);
                wr_idx[1] = rd1_idx;
                uptr = {s_q.ext[regfile_pkg::USP_EXT], rd1_data};
                if (op == regfile_pkg::OP_USP_PUSH)
                begin
                    uptr_next = uptr - step;
                    s_d.stk_addr = uptr_next[19:0];
                    s_d.stk_we = 1'b1;
                end
                else
                begin
                    uptr_next = uptr + step;
                    s_d.stk_addr = uptr[19:0];
                end
                wr_en[1] = 1'b1;
                wr_data[1] = uptr_next[15:0];
                s_d.ext[regfile_pkg::USP_EXT] = uptr_next[23:16];
            end
            // [RULE10] explicit bank select
            regfile_pkg::OP_SEL_BANK:
            begin
                s_d.processor_status_word[regfile_pkg::PSW_BANK_LSB +: regfile_pkg::BANK_W] =
                    wdata[2:0];
            end
            // [RULE16] [RULE17] context save into the new bank
            regfile_pkg::OP_CTX_SWITCH:
            begin
                wr_en = 2'b11;
                wr_idx[0] = regfile_pkg::pair_index(ctx_bank,
                    regfile_pkg::CTX_PC_LOW_PAIR);
                wr_be[0] = 2'b11;
                wr_data[0] = ctx_pc[15:0];
                wr_idx[1] = regfile_pkg::pair_index(ctx_bank,
                    regfile_pkg::CTX_PC_HIGH_PAIR);
                wr_data[1] = {s_q.processor_status_word[15:12], ctx_pc[19:16], s_q.processor_status_word[7:0]};
                s_d.processor_status_word[regfile_pkg::PSW_BANK_LSB +: regfile_pkg::BANK_W] =
                    ctx_bank;
            end
            regfile_pkg::OP_PSW_WR:
            begin
                s_d.processor_status_word = wdata[15:0];
            end
            // [RULE18] status pushed on vector acknowledge
            regfile_pkg::OP_VEC_ACK:
            begin
                s_d.sp = s_q.sp - regfile_pkg::PSW_STACK_BYTES;
                s_d.stk_addr = s_d.sp[19:0];
                s_d.stk_wdata = s_q.processor_status_word;
                s_d.stk_we = 1'b1;
            end
            // [RULE18] status restored on return
            regfile_pkg::OP_INT_RET:
            begin
                s_d.stk_addr = sp_addr;
                s_d.sp = s_q.sp + regfile_pkg::PSW_STACK_BYTES;
                s_d.processor_status_word = wdata[15:0];
            end
            // [RULE12] window access, bank-major byte order
            regfile_pkg::OP_MEM_RD, regfile_pkg::OP_MEM_WR:
            begin
                rd0_idx = win_off[6:1];
                wr_idx[0] = win_off[6:1];
                wr_be[0] = win_off[0] ? 2'b10 : 2'b01;
                wr_data[0] = {wdata[31:24], wdata[31:24]};
                wr_en[0] = win_hit && (op == regfile_pkg::OP_MEM_WR);
                s_d.mem_hit = win_hit;
                s_d.rdata = {24'h000000,
                    win_off[0] ? rd0_data[15:8] : rd0_data[7:0]};
            end
            default:
            begin
            end
        endcase
    end

    // ========================================================
    // state register
    // ========================================================
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // [RULE11] bank zero after reset
            s_q <= '0;
            s_q.processor_status_word <= regfile_pkg::PSW_RESET;
            s_q.sp <= regfile_pkg::SP_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign done_q = s_q.done;
    assign rdata_q = s_q.rdata;
    assign zero_q = s_q.zero;
    assign psw_q = s_q.processor_status_word;
    assign sp_q = s_q.sp;
    assign sp_valid_q = s_q.sp_valid;
    assign stk_addr_q = s_q.stk_addr;
    assign stk_wdata_q = s_q.stk_wdata;
    assign stk_we_q = s_q.stk_we;
    assign mem_hit_q = s_q.mem_hit;
    assign nmi_accept_q = s_q.nmi_accept;

    // ========================================================
    // checks
    // ========================================================
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    a_push_pre_dec: assert property ( // [RULE3]
        op == regfile_pkg::OP_SP_PUSH && sel[1:0] != 2'b00 |=>
        stk_we_q && stk_addr_q == sp_q[19:0] && sp_q != $past(sp_q))
        else $error("push address is not the decremented pointer");

    a_pop_post_inc: assert property ( // [RULE3]
        op == regfile_pkg::OP_SP_POP |=>
        stk_addr_q == $past(sp_addr) && !stk_we_q)
        else $error("pop did not use the old pointer");

    a_bank_select_now: assert property ( // [RULE10]
        op == regfile_pkg::OP_SEL_BANK |=> psw_q[14:12] == $past(wdata[2:0]))
        else $error("bank field not taken from select");

    a_ctx_pc_saved: assert property ( // [RULE16]
        op == regfile_pkg::OP_CTX_SWITCH ##1
        (op == regfile_pkg::OP_RD16 && !implicit && sel == 4'h2) |=>
        rdata_q[15:0] == $past(ctx_pc[15:0], 2))
        else $error("pair 2 does not hold the saved counter");

    a_ctx_status_saved: assert property ( // [RULE17]
        op == regfile_pkg::OP_CTX_SWITCH ##1
        (op == regfile_pkg::OP_RD16 && !implicit && sel == 4'h3) |=>
        rdata_q[11:8] == $past(ctx_pc[19:16], 2) &&
        rdata_q[7:0] == $past(psw_q[7:0], 2))
        else $error("pair 3 does not hold counter top and status");

    a_vec_psw_push: assert property ( // [RULE18]
        op == regfile_pkg::OP_VEC_ACK |=>
        stk_we_q && stk_wdata_q == $past(psw_q))
        else $error("status not pushed on acknowledge");

    a_remap_implicit: assert property ( // [RULE14]
        op inside {regfile_pkg::OP_RD8, regfile_pkg::OP_WR8} &&
        implicit && remap |-> map_widx[2:1] == 2'b01)
        else $error("remapped implicit byte outside registers 4..7");

    a_absolute_name: assert property ( // [RULE15]
        op == regfile_pkg::OP_RD8 && !implicit |->
        map_widx == {bank, sel[3:1]} && map_hi == sel[0])
        else $error("absolute register number altered");

    a_loop_zero_flag: assert property ( // [RULE20]
        op == regfile_pkg::OP_LOOP_DEC |=>
        zero_q == (rdata_q[7:0] == 8'h00) && done_q)
        else $error("loop counter zero flag wrong");

    a_window_reloc: assert property ( // [RULE13]
        op == regfile_pkg::OP_MEM_RD && wdata[19:0] == 20'h0FE80 |=>
        mem_hit_q == !$past(location_high))
        else $error("window placement wrong");

    a_nmi_unmasked: assert property ( // [RULE5]
        nmi_req && !sp_valid_q |=> nmi_accept_q)
        else $error("request dropped before pointer load");

    c_ctx_switch: cover property (op == regfile_pkg::OP_CTX_SWITCH);
    c_loop_to_zero: cover property (
        op == regfile_pkg::OP_LOOP_DEC ##1 zero_q);
    c_vec_then_ret: cover property (
        op == regfile_pkg::OP_VEC_ACK ##[1:20] op == regfile_pkg::OP_INT_RET);
    c_remapped_read: cover property (
        op == regfile_pkg::OP_RD16 && implicit && remap);

endmodule

`default_nettype wire

// [core/reg_name_map.sv]
// Purpose: turn a register name into a RAM word index and byte lane
// Assumes: bank and remap come straight from the status word
// Notes:   purely combinational
`default_nettype none

module reg_name_map (
    input wire logic [2:0] bank,
    input wire logic remap,
    input wire logic implicit,
    input wire logic wide,
    input wire logic [3:0] num,
    output logic [5:0] widx,
    output logic hi
);

    // [RULE14] implicit names follow remap
    // [RULE15] absolute numbers pass through
    function automatic logic [3:0] byte_reg(input logic rm,
                                            input logic imp,
                                            input logic [3:0] n);
        byte_reg = imp ? {1'b0, rm, n[1:0]} : n;
    endfunction

    function automatic logic [2:0] word_reg(input logic rm,
                                            input logic imp,
                                            input logic [3:0] n);
        word_reg = imp ? {1'b0, rm, n[0]} : n[2:0];
    endfunction

    logic [3:0] r;

    // ========================================================
    // name decode
    // ========================================================
    always_comb
    begin
        r = byte_reg(remap, implicit, num);
        if (wide)
        begin
            widx = regfile_pkg::pair_index(bank,
                word_reg(remap, implicit, num));
            hi = 1'b0;
        end
        else
        begin
            widx = regfile_pkg::pair_index(bank, r[3:1]);
            hi = r[0];
        end
    end

endmodule

`default_nettype wire

// [core/regbank_ram.sv]
// Purpose: storage for all banks of paired byte registers
// Assumes: asynchronous reads, writes on the clock edge
// Notes:   port 1 wins over port 0 when both write one byte
`default_nettype none

module regbank_ram #(
    parameter int WORDS = 64
) (
    input wire logic mclk,
    input wire logic [5:0] rd0_idx,
    output logic [15:0] rd0_data,
    input wire logic [5:0] rd1_idx,
    output logic [15:0] rd1_data,
    input wire logic [1:0] wr_en,
    input wire logic [1:0][5:0] wr_idx,
    input wire logic [1:0][1:0] wr_be,
    input wire logic [1:0][15:0] wr_data
);

    logic [15:0] mem [0:WORDS-1];

    assign rd0_data = mem[rd0_idx];
    assign rd1_data = mem[rd1_idx];

    // ========================================================
    // byte-lane writes, two ports
    // ========================================================
    always_ff @(posedge mclk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (wr_en[p] && wr_be[p][0])
            begin
                mem[wr_idx[p]][7:0] <= wr_data[p][7:0];
            end
            if (wr_en[p] && wr_be[p][1])
            begin
                mem[wr_idx[p]][15:8] <= wr_data[p][15:8];
            end
        end
    end

endmodule

`default_nettype wire

// [inc/regfile_pkg.sv]
// Purpose: shared constants, operation codes and index helper for the
//          banked general register file and stack pointer
// Assumes: one core clock, byte registers paired little-end first
// Notes:   the bank and remap positions, fixed pair numbers and window offsets used by the core live here
`default_nettype none

package regfile_pkg;

    // ========================================================
    // sizes
    // ========================================================
    localparam int SP_W = 24;
    localparam int ADDR_W = 20;
    localparam int WORD_IDX_W = 6;
    localparam int BANK_W = 3;

    // ========================================================
    // status word layout
    // ========================================================
    localparam int PSW_BANK_LSB = 12;
    localparam int PSW_REMAP_BIT = 5;
    localparam logic [15:0] PSW_RESET = 16'h0000;
    localparam logic [23:0] SP_RESET = 24'h000000;

    // ========================================================
    // fixed pair numbers inside a bank
    // ========================================================
    localparam logic [2:0] CTX_PC_LOW_PAIR = 3'h2;
    localparam logic [2:0] CTX_PC_HIGH_PAIR = 3'h3;
    localparam logic [2:0] USP_PAIR = 3'h5;
    localparam logic [1:0] USP_EXT = 2'h1;
    localparam logic [2:0] QUAD_LOW_PAIR = 3'h6;
    localparam logic [3:0] LOOP_C_CODE = 4'h2;
    localparam logic [23:0] PSW_STACK_BYTES = 24'h000002;

    // ========================================================
    // data memory window over the bank RAM
    // ========================================================
    localparam logic [19:0] RF_BASE_LOW = 20'h0FE80;
    localparam logic [19:0] RF_WIN_SIZE = 20'h00080;
    localparam logic [19:0] RELOC_OFFSET = 20'hF0000;

    typedef enum logic [4:0] {
        OP_NOP, OP_RD8, OP_WR8, OP_RD16, OP_WR16, OP_RD24, OP_WR24,
        OP_RD32, OP_WR32, OP_LOOP_DEC, OP_SP_LOAD, OP_SP_PUSH,
        OP_SP_POP, OP_USP_PUSH, OP_USP_POP, OP_SEL_BANK, OP_CTX_SWITCH,
        OP_PSW_WR, OP_VEC_ACK, OP_INT_RET, OP_MEM_RD, OP_MEM_WR
    } op_t;

    function automatic logic [5:0] pair_index(input logic [2:0] bank,
                                              input logic [2:0] pair);
        pair_index = {bank, pair};
    endfunction

endpackage

`default_nettype wire

// [tb/test_banked_register_file_stack.sv]
// Purpose: self-checking bench for the banked register file and stack
// Assumes: every op but OP_NOP answered one edge later, inputs driven at negedge
// Notes:   bank ram is written before it is read back
`default_nettype none

module test_banked_register_file_stack;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic implicit = 1'b0;
    logic location_high = 1'b0;
    logic nmi_req = 1'b0;
    regfile_pkg::op_t op = regfile_pkg::OP_NOP;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic done_q, zero_q, sp_valid_q, stk_we_q, mem_hit_q, nmi_accept_q;
    logic [31:0] rdata_q;
    logic [15:0] psw_q, stk_wdata_q;
    logic [23:0] sp_q;
    logic [19:0] stk_addr_q;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    always #2.5 mclk = ~mclk;

    banked_register_file_stack #(.BANKS(8)) dut_u (
        .mclk, .reset_n, .op, .sel, .implicit, .wdata, .location_high,
        .nmi_req, .done_q, .rdata_q, .zero_q, .psw_q, .sp_q, .sp_valid_q,
        .stk_addr_q, .stk_wdata_q, .stk_we_q, .mem_hit_q, .nmi_accept_q
    );

    // ========================================================
    // helpers
    // ========================================================
    task automatic final_report;
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one op, sampled at the next rising edge, results read at negedge
    task automatic go(input regfile_pkg::op_t o, input logic [3:0] s,
                      input logic i, input logic [31:0] w);
        op = o;
        sel = s;
        implicit = i;
        wdata = w;
        @(posedge mclk);
        @(negedge mclk);
        chk(32'(done_q), 32'h1);
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 500)
        begin
            failures++;
            final_report;
        end
    end

    // ========================================================
    // main sequence
    // ========================================================
    initial
    begin
        repeat (6) @(negedge mclk);
        reset_n = 1'b1;
        nmi_req = 1'b1;
        chk(32'(psw_q), 32'h0);
        go(regfile_pkg::OP_WR16, 4'h2, 1'b0, 32'h1234);
        chk(32'(nmi_accept_q), 32'h1);
        nmi_req = 1'b0;
        go(regfile_pkg::OP_RD16, 4'h2, 1'b0, 32'h0);
        chk(rdata_q, 32'h1234);
        go(regfile_pkg::OP_SP_LOAD, 4'h0, 1'b0, 32'hFEE0);
        chk(32'(sp_valid_q), 32'h1);
        go(regfile_pkg::OP_SP_PUSH, 4'h2, 1'b0, 32'h0);
        chk(32'(sp_q), 32'hFEDE);
        chk(32'(stk_we_q), 32'h1);
        go(regfile_pkg::OP_SP_POP, 4'h2, 1'b0, 32'h0);
        chk(32'(stk_addr_q), 32'hFEDE);
        chk(32'(sp_q), 32'hFEE0);
        go(regfile_pkg::OP_SEL_BANK, 4'h0, 1'b0, 32'h5);
        chk(32'(psw_q[14:12]), 32'h5);
        go(regfile_pkg::OP_PSW_WR, 4'h0, 1'b0, 32'h20);
        go(regfile_pkg::OP_WR8, 4'h1, 1'b1, 32'h5A);
        go(regfile_pkg::OP_RD8, 4'h5, 1'b0, 32'h0);
        chk(32'(rdata_q[7:0]), 32'h5A);
        go(regfile_pkg::OP_VEC_ACK, 4'h0, 1'b0, 32'h0);
        chk(32'(stk_wdata_q), 32'h20);
        chk(32'(sp_q), 32'hFEDE);
        go(regfile_pkg::OP_INT_RET, 4'h0, 1'b0, 32'h3000);
        chk(32'(psw_q), 32'h3000);
        chk(32'(sp_q), 32'hFEE0);
        go(regfile_pkg::OP_CTX_SWITCH, 4'h0, 1'b0, 32'h25ABCD);
        chk(32'(psw_q[14:12]), 32'h2);
        go(regfile_pkg::OP_RD16, 4'h3, 1'b0, 32'h0);
        chk(32'(rdata_q[15:0]), 32'h3500);
        go(regfile_pkg::OP_CTX_SWITCH, 4'h0, 1'b0, 32'h25ABCD);
        go(regfile_pkg::OP_RD16, 4'h2, 1'b0, 32'h0);
        chk(32'(rdata_q[15:0]), 32'hABCD);
        go(regfile_pkg::OP_WR32, 4'h0, 1'b1, 32'h11223344);
        go(regfile_pkg::OP_RD32, 4'h0, 1'b1, 32'h0);
        chk(rdata_q, 32'h11223344);
        go(regfile_pkg::OP_WR24, 4'h1, 1'b0, 32'hA1B2C3);
        go(regfile_pkg::OP_RD24, 4'h1, 1'b0, 32'h0);
        chk(32'(rdata_q[23:0]), 32'hA1B2C3);
        go(regfile_pkg::OP_USP_PUSH, 4'h2, 1'b0, 32'h0);
        chk(32'(stk_addr_q), 32'h1B2C1);
        chk(32'(stk_we_q), 32'h1);
        chk(32'(sp_q), 32'hFEE0);
        go(regfile_pkg::OP_USP_POP, 4'h2, 1'b0, 32'h0);
        chk(32'(stk_addr_q), 32'h1B2C1);
        go(regfile_pkg::OP_RD24, 4'h1, 1'b0, 32'h0);
        chk(32'(rdata_q[23:0]), 32'hA1B2C3);
        go(regfile_pkg::OP_WR8, 4'h2, 1'b0, 32'h1);
        go(regfile_pkg::OP_LOOP_DEC, 4'h0, 1'b1, 32'h0);
        chk(32'(zero_q), 32'h1);
        go(regfile_pkg::OP_WR8, 4'h3, 1'b0, 32'h2);
        go(regfile_pkg::OP_LOOP_DEC, 4'h1, 1'b1, 32'h0);
        chk(rdata_q, 32'h1);
        chk(32'(zero_q), 32'h0);
        go(regfile_pkg::OP_MEM_RD, 4'h0, 1'b0, 32'hFE80);
        chk(32'(mem_hit_q), 32'h1);
        location_high = 1'b1;
        go(regfile_pkg::OP_MEM_RD, 4'h0, 1'b0, 32'hFE80);
        chk(32'(mem_hit_q), 32'h0);
        go(regfile_pkg::OP_MEM_WR, 4'h0, 1'b0, 32'h770FFEA4);
        chk(32'(mem_hit_q), 32'h1);
        go(regfile_pkg::OP_RD8, 4'h4, 1'b0, 32'h0);
        chk(32'(rdata_q[7:0]), 32'h77);
        op = regfile_pkg::OP_NOP;
        final_report;
    end
endmodule

`default_nettype wire
